// *** pss_pkg.sv ***
package pss_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int FC_W = 8;
	localparam int IRQ_W = 4;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_SUMMARY = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_FC_COUNT = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h1A;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h1B;

	// status summary field positions
	localparam int SUM_LINK_BIT = 0;
	localparam int SUM_SPEED_IS_TEN_MEG_BIT = 1;
	localparam int SUM_DUPLEX_BIT = 2;
	localparam int SUM_LOOPBACK_BIT = 3;
	localparam int SUM_AN_DONE_BIT = 4;
	localparam int SUM_JABBER_BIT = 5;
	localparam int SUM_FC_LATCH_BIT = 11;

	// false carrier count field
	localparam int FC_LSB = 0;
	localparam int FC_MSB = 7;
	localparam logic [FC_W-1:0] FC_RESET = 8'h00;
	localparam logic [FC_W-1:0] FC_ONE = 8'h01;
	localparam logic [FC_W-1:0] FC_MAX = 8'hFF;

	// interrupt status and mask bit positions
	localparam int IRQ_FC_BIT = 0;
	localparam int IRQ_LINK_BIT = 1;
	localparam int IRQ_JABBER_BIT = 2;
	localparam int IRQ_AN_DONE_BIT = 3;

	localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

	// live status from the phy core
	typedef struct packed {
		logic jabber;
		logic an_done;
		logic loopback;
		logic full_duplex;
		logic speed_is_ten_meg;
		logic link_up;
	} pss_status_t;

	localparam pss_status_t STATUS_RESET = '{default: 1'b0};

	typedef struct packed {
		pss_status_t mirror;
		logic fc_latch;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_mask;
		logic [DATA_W-1:0] rd_data;
		logic irq;
	} pss_top_state_t;

	typedef struct packed {
		logic [FC_W-1:0] count;
	} pss_cnt_state_t;

endpackage

// *** pss_sat_counter.sv ***
`timescale 1ns/1ps
module pss_sat_counter (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic inc,
	input wire logic clr,
	output logic [pss_pkg::FC_W-1:0] count
);
	pss_pkg::pss_cnt_state_t st_r;
	pss_pkg::pss_cnt_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		// an event in the clearing cycle is kept as the first count
		if (clr) begin
			st_nxt.count = inc ? pss_pkg::FC_ONE : pss_pkg::FC_RESET;
		end else if (inc && st_r.count != pss_pkg::FC_MAX) begin
			st_nxt.count = st_r.count + pss_pkg::FC_ONE;
		end
		// no wrap, so a full count still means at least that many events
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_r.count <= pss_pkg::FC_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign count = st_r.count;
endmodule

// *** pss_phy_status.sv ***
`timescale 1ns/1ps
// What this block does
// - jabber detected shown in summary bit 5
// - jabber mirrors basic status, read keeps it
// - bit 4 high once autonegotiation completes
// - bit 3 high while loopback enabled
// - bit 2 resolved duplex, one is full
// - bit 1 resolved speed, one is ten
// - bit 0 high while valid link exists
// - link mirrors basic status, read keeps it
// - count register upper byte zero, writes ignored
// - eight bit false carrier event counter
// - counter sticks at its maximum value
// - counter resets zero, read only, clears on read
// - summary latch set by event, cleared counter read
module pss_phy_status (
	input wire logic ref_clk,
	input wire logic reset,
	input wire pss_pkg::pss_status_t phy_status,
	input wire logic false_carrier_event,
	input wire logic [pss_pkg::ADDR_W-1:0] addr,
	input wire logic [pss_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [pss_pkg::DATA_W-1:0] rd_data,
	output logic irq
);
	pss_pkg::pss_top_state_t st_r;
	pss_pkg::pss_top_state_t st_nxt;
	logic [pss_pkg::FC_W-1:0] fc_count;
	logic fc_read;
	logic [pss_pkg::IRQ_W-1:0] irq_events;
	logic [pss_pkg::DATA_W-1:0] summary_word;
	logic [pss_pkg::DATA_W-1:0] fc_word;

	assign fc_read = rd_en && addr == pss_pkg::OFS_FC_COUNT;

	pss_sat_counter u_fc_count (
		.ref_clk(ref_clk),
		.reset(reset),
		.inc(false_carrier_event),
		.clr(fc_read),
		.count(fc_count)
	);

	always_comb begin
		summary_word = pss_pkg::DATA_ZERO;
		summary_word[pss_pkg::SUM_JABBER_BIT] = st_r.mirror.jabber;
		summary_word[pss_pkg::SUM_AN_DONE_BIT] = st_r.mirror.an_done;
		summary_word[pss_pkg::SUM_LOOPBACK_BIT] = st_r.mirror.loopback;
		summary_word[pss_pkg::SUM_DUPLEX_BIT] = st_r.mirror.full_duplex;
		summary_word[pss_pkg::SUM_SPEED_IS_TEN_MEG_BIT] = st_r.mirror.speed_is_ten_meg;
		summary_word[pss_pkg::SUM_LINK_BIT] = st_r.mirror.link_up;
		summary_word[pss_pkg::SUM_FC_LATCH_BIT] = st_r.fc_latch;
		fc_word = pss_pkg::DATA_ZERO;
		fc_word[pss_pkg::FC_MSB:pss_pkg::FC_LSB] = fc_count;
	end

	always_comb begin
		irq_events = pss_pkg::IRQ_RESET;
		irq_events[pss_pkg::IRQ_FC_BIT] = false_carrier_event;
		irq_events[pss_pkg::IRQ_LINK_BIT] = phy_status.link_up != st_r.mirror.link_up;
		irq_events[pss_pkg::IRQ_JABBER_BIT] = phy_status.jabber && !st_r.mirror.jabber;
		irq_events[pss_pkg::IRQ_AN_DONE_BIT] = phy_status.an_done && !st_r.mirror.an_done;
	end

	always_comb begin
		st_nxt = st_r;
		// plain copies; nothing here clears on a summary read
		st_nxt.mirror = phy_status;
		// set wins so an event during the clearing read is kept
		if (false_carrier_event) begin
			st_nxt.fc_latch = 1'b1;
		end else if (fc_read) begin
			st_nxt.fc_latch = 1'b0;
		end
		if (wr_en && addr == pss_pkg::OFS_IRQ_STATUS) begin
			st_nxt.irq_status = st_r.irq_status & ~wr_data[pss_pkg::IRQ_W-1:0];
		end
		st_nxt.irq_status = st_nxt.irq_status | irq_events;
		if (wr_en && addr == pss_pkg::OFS_IRQ_MASK) begin
			st_nxt.irq_mask = wr_data[pss_pkg::IRQ_W-1:0];
		end
		// writes to the summary and count offsets fall through untouched
		st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);
		st_nxt.rd_data = pss_pkg::DATA_ZERO;
		if (rd_en) begin
			unique case (addr)
				pss_pkg::OFS_SUMMARY: begin
					st_nxt.rd_data = summary_word;
				end
				pss_pkg::OFS_FC_COUNT: begin
					st_nxt.rd_data = fc_word;
				end
				pss_pkg::OFS_IRQ_STATUS: begin
					st_nxt.rd_data[pss_pkg::IRQ_W-1:0] = st_r.irq_status;
				end
				pss_pkg::OFS_IRQ_MASK: begin
					st_nxt.rd_data[pss_pkg::IRQ_W-1:0] = st_r.irq_mask;
				end
				default: begin
					st_nxt.rd_data = pss_pkg::DATA_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_r.mirror <= pss_pkg::STATUS_RESET;
			st_r.fc_latch <= 1'b0;
			st_r.irq_status <= pss_pkg::IRQ_RESET;
			st_r.irq_mask <= pss_pkg::IRQ_RESET;
			st_r.rd_data <= pss_pkg::DATA_ZERO;
			st_r.irq <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_data = st_r.rd_data;
	assign irq = st_r.irq;
endmodule

// *** pss_phy_status_monitor.sv ***
`timescale 1ns/1ps
module pss_phy_status_monitor (
	input wire logic ref_clk,
	input wire logic reset,
	input wire pss_pkg::pss_status_t phy_status,
	input wire logic false_carrier_event,
	input wire logic [pss_pkg::ADDR_W-1:0] addr,
	input wire logic [pss_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [pss_pkg::DATA_W-1:0] rd_data,
	input wire logic irq
);
	wire rs = rd_en && addr == pss_pkg::OFS_SUMMARY;
	wire rf = rd_en && addr == pss_pkg::OFS_FC_COUNT;
	wire ev = false_carrier_event;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	// an event inside the gap would count again
	sequence s_fc_clr;
		rf && !ev ##1 !ev;
	endsequence
	a_sum_fields: assert property (rs |=> rd_data[5:0] == $past(phy_status, 2))
		else $error("summary fields");
	a_sum_zero: assert property (rs |=> rd_data[15:12] == 4'h0 && rd_data[10:6] == 5'h00)
		else $error("summary spare");
	a_fc_upper: assert property (rf |=> rd_data[15:8] == 8'h00)
		else $error("count upper");
	a_rd_idle: assert property (!rd_en |=> rd_data == 16'h0000)
		else $error("idle data");
	a_fc_clear: assert property (s_fc_clr ##1 rf |=> rd_data == 16'h0000)
		else $error("count clear");
	a_latch_set: assert property (ev ##1 rs |=> rd_data[11])
		else $error("latch set");
	a_latch_clr: assert property (s_fc_clr ##1 rs |=> !rd_data[11])
		else $error("latch clear");
	a_no_map: assert property (rd_en && addr == 5'h03 |=> rd_data == 16'h0000)
		else $error("unmapped");
endmodule
bind pss_phy_status pss_phy_status_monitor pss_phy_status_monitor_inst (.ref_clk, .reset,
	.phy_status, .false_carrier_event, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .irq);

// *** pss_core_model.sv ***
`timescale 1ns/1ps
module pss_core_model (
	input wire logic ref_clk,
	input wire pss_pkg::pss_status_t st_req,
	input wire logic ev_req,
	output pss_pkg::pss_status_t phy_status,
	output logic false_carrier_event
);
	// core is same-clock logic, one flop stands in for it
	always_ff @(posedge ref_clk) begin
		phy_status <= st_req;
		false_carrier_event <= ev_req;
	end
endmodule

// *** tb_pss_phy_status.sv ***
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fail_count++; \
	$display("mismatch %s exp %h got %h", n, e, s); end end
module tb_pss_phy_status;
	logic ref_clk = 0, reset = 1, ev_req = 0, wr_en = 0, rd_en = 0, rd_q = 0, irq;
	logic false_carrier_event;
	logic [4:0] addr = 5'h00;
	logic [15:0] wr_data = 16'h0000, rd_data, e;
	logic [15:0] q[$];
	pss_pkg::pss_status_t st = 6'h00, phy_status;
	int fail_count = 0, num_checks = 0, seed = 23876, n, k;
	pss_core_model pss_core_model_inst (.ref_clk, .st_req(st), .ev_req, .phy_status,
		.false_carrier_event);
	pss_phy_status pss_phy_status_inst (.ref_clk, .reset, .phy_status, .false_carrier_event,
		.addr, .wr_data, .wr_en, .rd_en, .rd_data, .irq);
	initial forever #25 ref_clk = ~ref_clk;
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1;
		@(posedge ref_clk);
		wr_en <= 0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] x);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1;
		q.push_back(x);
		@(posedge ref_clk);
		rd_en <= 0;
	endtask
	task automatic ev(input int c);
		repeat (c) begin
			@(posedge ref_clk);
			ev_req <= 1;
			@(posedge ref_clk);
			ev_req <= 0;
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		rd_q <= rd_en;
		if (rd_q) begin
			e = q.pop_front();
			`CHK("rd_data", e, rd_data)
		end
	end
	initial begin
		#100000;
		fail_count++;
		conclude();
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		reset <= 0;
		rd(5'h10, 16'h0000);
		rd(5'h14, 16'h0000);
		rd(5'h03, 16'h0000);
		repeat (8) begin
			n = $random(seed);
			st <= n[5:0];
			wr(5'h10, n[31:16]);
			repeat (3) @(posedge ref_clk);
			rd(5'h10, {10'h000, st});
			rd(5'h10, {10'h000, st});
		end
		n = $random(seed);
		k = n[3:0] + 1;
		ev(k);
		rd(5'h10, {10'h020, st});
		wr(5'h14, 16'hFFFF);
		rd(5'h14, 16'(k));
		rd(5'h14, 16'h0000);
		rd(5'h10, {10'h000, st});
		ev(300);
		rd(5'h14, 16'h00FF);
		wr(5'h1A, 16'h000F);
		wr(5'h1B, 16'h0001);
		ev(1);
		repeat (2) @(posedge ref_clk);
		`CHK("irq", 1'b1, irq)
		rd(5'h1A, 16'h0001);
		wr(5'h1A, 16'h0001);
		repeat (2) @(posedge ref_clk);
		`CHK("irq", 1'b0, irq)
		wr(5'h1B, 16'h0000);
		ev(1);
		repeat (2) @(posedge ref_clk);
		`CHK("irq", 1'b0, irq)
		// quiet status, then raise jabber, autoneg done and link together
		st <= 6'h00;
		repeat (3) @(posedge ref_clk);
		wr(5'h1A, 16'h000F);
		wr(5'h1B, 16'h000E);
		st <= 6'h31;
		repeat (3) @(posedge ref_clk);
		`CHK("irq", 1'b1, irq)
		rd(5'h1A, 16'h000E);
		rd(5'h1B, 16'h000E);
		repeat (2) @(posedge ref_clk);
		conclude();
	end
endmodule
